// [dv/hrp_loader.sv]
// Configuration loader model: byte writes, then load completion
`timescale 1ns/1ps
`default_nettype none
module hrp_loader
	import hrp_pkg::*;
(
	input wire logic mclk,
	output logic load_done,
	output hrp_wr_t cfg_wr
);
	initial
	begin
		cfg_wr = '0;
		load_done = 1'b0;
	end
	task automatic put(input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge mclk);
		cfg_wr <= '{en: 1'b1, addr: a, data: d};
		@(negedge mclk);
		cfg_wr <= '{en: 1'b0, addr: ~a, data: ~d};
	end
	endtask
	task automatic fin();
	begin
		load_done <= 1'b1;
	end
	endtask
endmodule
`default_nettype wire

// [dv/hrp_release_power_tb.sv]
// Self-checking bench for the release number and power configuration bank
`timescale 1ns/1ps
`default_nettype none
module hrp_release_power_tb;
	import hrp_pkg::*;
	logic mclk, rst, dyn, fst, pin, ld, load_done, rd_valid, self_pw, hs_cap, hs_inh, ppt;
	logic ds_off, us_disc;
	logic [7:0] rd_data;
	logic [15:0] rel_num;
	hrp_wr_t cfg_wr;
	hrp_rd_t cfg_rd;
	int fails = 0, cmp_count = 0, rel, cfg, n, k;
	// Reference copy of the three registers, offset 04h first
	int mdl [3] = '{RELEASE_LOW_RST, RELEASE_HIGH_RST, HUB_CONFIG_ONE_RST};
	hrp_loader ldr(.mclk(mclk), .load_done(load_done), .cfg_wr(cfg_wr));
	hrp_release_power DUT(.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.load_done(load_done), .dynamic_power_en(dyn), .host_force_single_tt(fst),
		.local_supply_present(pin), .rd_data_reg(rd_data), .rd_valid_reg(rd_valid),
		.release_number_reg(rel_num), .self_powered_reg(self_pw), .hs_capable_reg(hs_cap),
		.high_speed_inhibit_reg(hs_inh), .per_port_translator_en_reg(ppt),
		.downstream_power_off_reg(ds_off), .upstream_disconnect_reg(us_disc));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
	begin
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		ldr.put(a, d);
		if (a == HUB_CONFIG_ONE_OFS)
			mdl[2] = int'(d & HUB_CONFIG_ONE_MASK);
		else if (a == RELEASE_LOW_OFS || a == RELEASE_HIGH_OFS)
			mdl[a - RELEASE_LOW_OFS] = int'(d);
	end
	endtask
	function automatic logic [7:0] mdl_rd(input logic [7:0] a);
	begin
		mdl_rd = UNMAPPED_READ;
		if (a >= RELEASE_LOW_OFS && a <= HUB_CONFIG_ONE_OFS)
			mdl_rd = 8'(mdl[a - RELEASE_LOW_OFS]);
	end
	endfunction
	// Read data stands one cycle only, so it is taken at the next falling edge
	task automatic rd(input logic [7:0] a);
	begin
		@(negedge mclk);
		cfg_rd <= '{en: 1'b1, addr: a};
		@(negedge mclk);
		chk({7'h00, rd_valid, rd_data}, {8'h01, mdl_rd(a)});
		cfg_rd <= '{en: 1'b0, addr: ~a};
	end
	endtask
	task automatic wrap_up();
	begin
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial
	begin
		rst = 1'b1;
		{dyn, fst, pin, ld} = 4'h0;
		cfg_rd = '0;
		n = $urandom(88);
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		rd(RELEASE_LOW_OFS);
		rd(RELEASE_HIGH_OFS);
		rd(HUB_CONFIG_ONE_OFS);
		for (n = 0; n < 8; n++)
		begin
			rel = $urandom & 16'hffff;
			cfg = $urandom & 8'hff;
			fst = n[1];
			wr(RELEASE_LOW_OFS, rel[7:0]);
			wr(RELEASE_HIGH_OFS, rel[15:8]);
			wr(HUB_CONFIG_ONE_OFS, cfg[7:0]);
			wr(8'h10 + n[7:0], ~cfg[7:0]);
			if (n == 2)
			begin
				ldr.fin();
				ld = 1'b1;
			end
			repeat (2) @(negedge mclk);
			chk(rel_num, {mdl[1][7:0], mdl[0][7:0]});
			rd(RELEASE_LOW_OFS);
			rd(RELEASE_HIGH_OFS);
			rd(HUB_CONFIG_ONE_OFS);
			rd(8'h30 + n[7:0]);
			chk({12'h000, self_pw, hs_cap, hs_inh, ppt}, {12'h000, ld & mdl[2][POWER_SOURCE_BIT],
				ld & ~mdl[2][HS_INHIBIT_BIT], mdl[2][HS_INHIBIT_BIT],
				mdl[2][TRANSLATOR_BIT] & ~fst});
		end
		dyn = 1'b1;
		for (n = 0; n < 2; n++)
		begin
			@(negedge mclk);
			pin = ~pin;
			// Bounded wait; a missing drop phase shows as a mismatch below
			for (k = 0; ds_off !== 1'b1 && k < 10; k++)
				@(negedge mclk);
			chk({15'h0000, ds_off}, 16'h0001);
			for (k = 0; ds_off === 1'b1 && k < 20; k++)
			begin
				chk({14'h0000, us_disc, self_pw}, {14'h0000, 1'b1, pin});
				@(negedge mclk);
			end
			chk({15'h0000, us_disc}, 16'h0000);
			chk(16'(k), 16'h0008);
		end
		wrap_up();
	end
endmodule
`default_nettype wire

// [pkg/hrp_pkg.sv]
// Constants and types for the hub release and power configuration bank
package hrp_pkg;
	localparam logic [7:0] RELEASE_LOW_OFS = 8'h04;
	localparam logic [7:0] RELEASE_HIGH_OFS = 8'h05;
	localparam logic [7:0] HUB_CONFIG_ONE_OFS = 8'h06;
	localparam logic [7:0] RELEASE_LOW_RST = 8'h00;
	localparam logic [7:0] RELEASE_HIGH_RST = 8'h00;
	localparam logic [7:0] HUB_CONFIG_ONE_RST = 8'h00;
	localparam int POWER_SOURCE_BIT = 7;
	localparam int RESERVED_BIT = 6;
	localparam int HS_INHIBIT_BIT = 5;
	localparam int TRANSLATOR_BIT = 4;
	localparam logic [7:0] HUB_CONFIG_ONE_MASK = 8'hbf;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int CLK_PERIOD_NS = 50;
	localparam int DROP_TIME_NS = 400;
	localparam int DROP_CYCLES = (DROP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] DROP_LOAD = 4'(DROP_CYCLES - 1);

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} hrp_wr_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
	} hrp_rd_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_DROP = 3'b010,
		ST_ATTACH = 3'b100
	} hrp_state_t;
endpackage

// [rtl/hrp_release_power.sv]
// Device release number and first configuration byte with power switching
// Notes on behaviour
// - Hold sixteen-bit BCD release number, report it
// - Low byte at 04h, high at 05h
// - EEPROM or SMBus loader writes the fields
// - Config bit 7: 0 bus, 1 self powered
// - Dynamic mode takes power from supply pin
// - Config bit 5 forces full-speed only attach
// - Config bit 4 enables per-port translators
// - Translator bit 0 single, host may force
// - Supply change in dynamic mode after load: power off, disconnect, re-attach
`timescale 1ns/1ps
`default_nettype none
module hrp_release_power
	import hrp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire hrp_wr_t cfg_wr,
	input wire hrp_rd_t cfg_rd,
	input wire logic load_done,
	input wire logic dynamic_power_en,
	input wire logic host_force_single_tt,
	input wire logic local_supply_present,
	output logic [7:0] rd_data_reg,
	output logic rd_valid_reg,
	output logic [15:0] release_number_reg,
	output logic self_powered_reg,
	output logic hs_capable_reg,
	output logic high_speed_inhibit_reg,
	output logic per_port_translator_en_reg,
	output logic downstream_power_off_reg,
	output logic upstream_disconnect_reg
);
	logic [7:0] release_number_low_reg;
	logic [7:0] release_number_high_reg;
	logic [7:0] hub_config_one_reg;
	logic supply_s1_reg;
	logic supply_s2_reg;
	logic supply_prev_reg;
	hrp_state_t state_reg;
	hrp_state_t state_next;
	logic [3:0] drop_cnt_reg;
	logic [3:0] drop_cnt_next;

	// Write decode
	wire wr_low = cfg_wr.en && (cfg_wr.addr == RELEASE_LOW_OFS);
	wire wr_high = cfg_wr.en && (cfg_wr.addr == RELEASE_HIGH_OFS);
	wire wr_cfg = cfg_wr.en && (cfg_wr.addr == HUB_CONFIG_ONE_OFS);

	// Read selection
	wire rd_is_low = cfg_rd.addr == RELEASE_LOW_OFS;
	wire rd_is_high = cfg_rd.addr == RELEASE_HIGH_OFS;
	wire rd_is_cfg = cfg_rd.addr == HUB_CONFIG_ONE_OFS;
	wire [7:0] rd_mux = rd_is_low ? release_number_low_reg :
		rd_is_high ? release_number_high_reg :
		rd_is_cfg ? hub_config_one_reg : UNMAPPED_READ;

	// Decoded configuration
	wire power_source_select = hub_config_one_reg[POWER_SOURCE_BIT];
	wire high_speed_inhibit = hub_config_one_reg[HS_INHIBIT_BIT];
	wire per_port_translator_en = hub_config_one_reg[TRANSLATOR_BIT];
	wire self_source = dynamic_power_en ? supply_s2_reg : power_source_select;
	wire tt_mode = per_port_translator_en && !host_force_single_tt;
	wire supply_change = dynamic_power_en && load_done && (supply_s2_reg != supply_prev_reg);
	wire drop_active = state_next == ST_DROP;

	always_comb
	begin
		state_next = state_reg;
		drop_cnt_next = drop_cnt_reg;
		case (state_reg)
			ST_RUN:
			begin
				drop_cnt_next = 4'h0;
			end
			ST_DROP:
			begin
				if (drop_cnt_reg == 4'h0)
					state_next = ST_ATTACH;
				else
					drop_cnt_next = drop_cnt_reg - 4'h1;
			end
			ST_ATTACH:
			begin
				state_next = ST_RUN;
			end
			default:
			begin
				state_next = ST_RUN;
				drop_cnt_next = 4'h0;
			end
		endcase
		if (supply_change)
		begin
			state_next = ST_DROP;
			drop_cnt_next = DROP_LOAD;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			release_number_low_reg <= RELEASE_LOW_RST;
			release_number_high_reg <= RELEASE_HIGH_RST;
			hub_config_one_reg <= HUB_CONFIG_ONE_RST;
		end
		else
		begin
			if (wr_low)
				release_number_low_reg <= cfg_wr.data;
			if (wr_high)
				release_number_high_reg <= cfg_wr.data;
			if (wr_cfg)
				hub_config_one_reg <= cfg_wr.data & HUB_CONFIG_ONE_MASK;
		end
	end

	// Supply pin synchroniser
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			supply_s1_reg <= 1'b0;
			supply_s2_reg <= 1'b0;
			supply_prev_reg <= 1'b0;
		end
		else
		begin
			supply_s1_reg <= local_supply_present;
			supply_s2_reg <= supply_s1_reg;
			supply_prev_reg <= supply_s2_reg;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_reg <= ST_RUN;
			drop_cnt_reg <= 4'h0;
			downstream_power_off_reg <= 1'b0;
			upstream_disconnect_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			drop_cnt_reg <= drop_cnt_next;
			downstream_power_off_reg <= drop_active;
			upstream_disconnect_reg <= drop_active;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			release_number_reg <= 16'h0000;
			self_powered_reg <= 1'b0;
			hs_capable_reg <= 1'b0;
			high_speed_inhibit_reg <= 1'b0;
			per_port_translator_en_reg <= 1'b0;
		end
		else
		begin
			rd_data_reg <= cfg_rd.en ? rd_mux : 8'h00;
			rd_valid_reg <= cfg_rd.en;
			release_number_reg <= {release_number_high_reg, release_number_low_reg};
			self_powered_reg <= load_done && self_source;
			hs_capable_reg <= load_done && !high_speed_inhibit;
			high_speed_inhibit_reg <= high_speed_inhibit;
			per_port_translator_en_reg <= tt_mode;
		end
	end

	a_release_low_wr: assert property (@(posedge mclk) disable iff (rst)
		wr_low |=> ##1 release_number_reg[7:0] == $past(cfg_wr.data, 2))
		else $error("release low byte not reported");
	a_release_high_wr: assert property (@(posedge mclk) disable iff (rst)
		wr_high |=> ##1 release_number_reg[15:8] == $past(cfg_wr.data, 2))
		else $error("release high byte not reported");
	a_release_read_back: assert property (@(posedge mclk) disable iff (rst)
		cfg_rd.en && rd_is_high |=> rd_valid_reg && rd_data_reg == release_number_reg[15:8])
		else $error("release high byte read mismatch");
	a_cfg_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
		cfg_rd.en && rd_is_cfg |=> rd_valid_reg && rd_data_reg[RESERVED_BIT] == 1'b0)
		else $error("reserved config bit not zero");
	a_self_static: assert property (@(posedge mclk) disable iff (rst)
		load_done && !dynamic_power_en |=> self_powered_reg == $past(power_source_select))
		else $error("self powered does not follow config bit");
	a_self_dynamic: assert property (@(posedge mclk) disable iff (rst)
		load_done && dynamic_power_en |=> self_powered_reg == $past(supply_s2_reg))
		else $error("self powered does not follow supply pin");
	a_hs_inhibit: assert property (@(posedge mclk) disable iff (rst)
		load_done && wr_cfg |=> ##1 hs_capable_reg == !$past(cfg_wr.data[HS_INHIBIT_BIT], 2))
		else $error("high speed capability wrong");
	a_tt_mode: assert property (@(posedge mclk) disable iff (rst)
		host_force_single_tt |=> !per_port_translator_en_reg)
		else $error("single translator not forced");
	a_drop_hold: assert property (@(posedge mclk) disable iff (rst)
		supply_change |=> (downstream_power_off_reg && upstream_disconnect_reg)[*8])
		else $error("drop phase too short");
	a_drop_end: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_DROP && drop_cnt_reg == 4'h0 && !supply_change
		|=> !upstream_disconnect_reg ##1 state_reg == ST_RUN)
		else $error("re-attach did not follow drop");
	a_gate_unloaded: assert property (@(posedge mclk) disable iff (rst)
		!load_done |=> !self_powered_reg && !hs_capable_reg)
		else $error("outputs driven before load done");

	c_supply_change: cover property (@(posedge mclk) disable iff (rst)
		supply_change ##[1:20] state_reg == ST_ATTACH);
	c_per_port_tt: cover property (@(posedge mclk) disable iff (rst)
		per_port_translator_en_reg && hs_capable_reg);
	c_full_speed_only: cover property (@(posedge mclk) disable iff (rst)
		load_done && high_speed_inhibit_reg && self_powered_reg);
endmodule
`default_nettype wire
